//--- verilog/port_split_cfg.svh
// Offsets, field positions, reset values and timing figures of the port split block.
// Assumes the includer compiles it once per unit; the guard stops double inclusion.
`ifndef PORT_SPLIT_CFG_SVH
`define PORT_SPLIT_CFG_SVH

// Register offsets on the hub configuration port
`define OFS_PORT_ENABLE      16'h3C48
`define OFS_GLOBAL_ENABLE    16'h4141
`define OFS_PORT5_PIN_SEL    16'h416E
`define OFS_PORT6_PIN_SEL    16'h416F
`define OFS_STUCK_TIMEOUT    16'h4171
`define OFS_PULSE_LENGTH     16'h4176
`define OFS_SPLIT_STATUS     16'h4177

// Reset values
`define RST_PORT_ENABLE      8'h00
`define RST_GLOBAL_ENABLE    8'h00
`define RST_PIN_SEL          8'h00
`define RST_STUCK_TIMEOUT    8'h05
`define RST_PULSE_LENGTH     8'h08

// Field positions
`define BIT_PORT5_ENABLE     5
`define BIT_PORT6_ENABLE     6
`define BIT_GLOBAL_ENABLE    0
`define MASK_PORT_ENABLE     8'hFE

// Pin selection codes
`define SEL_PORT5_OPTION_A   8'h42
`define SEL_PORT5_OPTION_B   8'h05
`define SEL_PORT6_OPTION_A   8'h06
`define SEL_PORT6_OPTION_B   8'h04

// Non-operational link training codes, inclusive range
`define STUCK_CODE_LOW       4'h4
`define STUCK_CODE_HIGH      4'h9

// Timing
`define CLK_PERIOD_NS        8
`define MS_PERIOD_NS         1000000
`define TIMEOUT_UNIT_MS      200
`define PULSE_UNIT_MS        50
`define PULSE_CODE_MIN       8'h07
`define PULSE_CODE_MAX       8'h3A

`endif

//--- verilog/port_split_pkg.sv
// Types shared by the port split watchdog and its top level.
// Assumes port_split_cfg.svh is compiled alongside for the numbers.
package port_split_pkg;

    // Watchdog phase
    typedef enum logic [0:0] {
        WATCH,
        PULSE
    } watch_phase_e;

    // Whole state of one port watchdog
    typedef struct packed {
        watch_phase_e phase;      // Watching or holding power low
        logic [3:0]   last_state; // Link state seen last cycle
        logic [15:0]  timer_ms;   // Milliseconds spent in current phase
    } watchdog_s;

    // Drive of one general-purpose pin, enable low while driving
    typedef struct packed {
        logic level;
        logic oe_n;
    } pin_drive_s;

    // Whole state of the top level
    typedef struct packed {
        logic [7:0]  port_enable;
        logic [7:0]  global_enable;
        logic [7:0]  port5_pin_sel;
        logic [7:0]  port6_pin_sel;
        logic [7:0]  stuck_timeout;
        logic [7:0]  pulse_length;
        logic [7:0]  rdata;
        logic [16:0] ms_count;
        logic        ms_tick;
    } split_regs_s;

endpackage

//--- verilog/link_watchdog.sv
// Stuck-link watchdog for one split port: times a frozen link state, pulses power low.
// Assumes a one-cycle millisecond tick and link state from the same clock domain.
`include "port_split_cfg.svh"

module link_watchdog (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        enable,     // Splitting active on this port
    input  wire logic        ms_tick,    // One pulse per millisecond
    input  wire logic [3:0]  link_state, // Link training state value
    input  wire logic [15:0] timeout_ms, // Zero disables the watchdog
    input  wire logic [15:0] pulse_ms,   // Low time of the power pulse
    output logic             power_low   // Hold split power pin low
);

    port_split_pkg::watchdog_s st_reg;  // Registered state
    port_split_pkg::watchdog_s st_next; // Next state
    logic                      stuck;   // Link sits in a non-operational code

    // Codes 0x4 to 0x9 are the states a healthy link never dwells in
    assign stuck = (link_state >= `STUCK_CODE_LOW) && (link_state <= `STUCK_CODE_HIGH);

    // Next-state logic
    always_comb begin
        st_next = st_reg;
        st_next.last_state = link_state;
        case (st_reg.phase)
            port_split_pkg::WATCH: begin
                // Any movement or a healthy code restarts the wait
                if (!enable || timeout_ms == 16'h0000 || !stuck
                    || link_state != st_reg.last_state) begin
                    st_next.timer_ms = 16'h0000;
                end else if (ms_tick) begin
                    if (st_reg.timer_ms + 16'h0001 >= timeout_ms) begin
                        // Expired: start pulse and restart timer for next round
                        st_next.phase    = port_split_pkg::PULSE;
                        st_next.timer_ms = 16'h0000;
                    end else begin
                        st_next.timer_ms = st_reg.timer_ms + 16'h0001;
                    end
                end
            end
            port_split_pkg::PULSE: begin
                // Disabling mid-pulse releases the pin on the next clock
                if (!enable) begin
                    st_next.phase    = port_split_pkg::WATCH;
                    st_next.timer_ms = 16'h0000;
                end else if (ms_tick) begin
                    if (st_reg.timer_ms + 16'h0001 >= pulse_ms) begin
                        st_next.phase    = port_split_pkg::WATCH;
                        st_next.timer_ms = 16'h0000;
                    end else begin
                        st_next.timer_ms = st_reg.timer_ms + 16'h0001;
                    end
                end
            end
            default: begin
                st_next.phase    = port_split_pkg::WATCH;
                st_next.timer_ms = 16'h0000;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg <= '{port_split_pkg::WATCH, 4'h0, 16'h0000};
        end else begin
            st_reg <= st_next;
        end
    end

    // Pin is low only during the pulse phase
    assign power_low = (st_reg.phase == port_split_pkg::PULSE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    disable_release_a: assert property (!enable |=> !power_low)
        else $error("Watchdog pulses while splitting is off");
    stuck_fire_a: assert property (
        (st_reg.phase == port_split_pkg::WATCH) && enable && stuck && ms_tick
        && link_state == st_reg.last_state && timeout_ms != 16'h0000
        && st_reg.timer_ms + 16'h0001 == timeout_ms |=> power_low)
        else $error("Stuck link did not start the power pulse");
    timer_restart_a: assert property ($rose(power_low) |-> st_reg.timer_ms == 16'h0000)
        else $error("Timer not restarted on timeout");
    change_clears_a: assert property (
        (st_reg.phase == port_split_pkg::WATCH) && link_state != st_reg.last_state
        |=> st_reg.timer_ms == 16'h0000)
        else $error("Link state change did not restart timer");
    zero_disables_a: assert property (
        (st_reg.phase == port_split_pkg::WATCH) && timeout_ms == 16'h0000
        |=> !power_low)
        else $error("Zero timeout still fired");
    healthy_clears_a: assert property (
        (st_reg.phase == port_split_pkg::WATCH) && !stuck |=> st_reg.timer_ms == 16'h0000)
        else $error("Healthy link state did not restart timer");
    pulse_end_a: assert property (
        power_low && enable && ms_tick && st_reg.timer_ms + 16'h0001 == pulse_ms
        |=> !power_low)
        else $error("Power pulse did not end at its length");

endmodule

//--- verilog/port_split_link_watchdog.sv
// Top of the port split block: configuration registers, pin routing and two watchdogs.
// Assumes configuration port, link states, OTP value and USB 2.0 power requests
// all come from logic on clk; the pins leave through pad logic outside.
`include "port_split_cfg.svh"

module port_split_link_watchdog #(
    parameter int MS_CYCLES = `MS_PERIOD_NS / `CLK_PERIOD_NS // Clock cycles per millisecond
) (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      cfg_wr_en,         // Register write strobe
    input  wire logic [15:0]               cfg_addr,          // Register offset
    input  wire logic [7:0]                cfg_wdata,         // Write data
    output logic [7:0]                     cfg_rdata,         // Read data, one cycle later
    input  wire logic                      otp_timeout_valid, // OTP timeout present
    input  wire logic [7:0]                otp_timeout_value, // OTP timeout code
    input  wire logic [3:0]                link_state_port5,  // Port 5 link training state
    input  wire logic [3:0]                link_state_port6,  // Port 6 link training state
    input  wire logic [1:0]                port_power_request,     // USB 2.0 power from hub
    output logic [1:0]                     port_power_control_pin, // USB 2.0 power pins
    output port_split_pkg::pin_drive_s     port5_option_a_pin,
    output port_split_pkg::pin_drive_s     port5_option_b_pin,
    output port_split_pkg::pin_drive_s     port6_option_a_pin,
    output port_split_pkg::pin_drive_s     port6_option_b_pin
);

    // Millisecond counter is 17 bits wide
    if (MS_CYCLES < 2 || MS_CYCLES > 131071) begin : g_bad_ms
        $error("MS_CYCLES must lie in 2..131071");
    end

    localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1); // Last count of a millisecond

    port_split_pkg::split_regs_s st_reg;   // Registered state
    port_split_pkg::split_regs_s st_next;  // Next state
    logic [1:0]                  active;   // Splitting in force per port
    logic [1:0]                  power_low; // Watchdog pulse per port
    logic [7:0]                  pin_sel [2];
    logic [7:0]                  sel_a   [2];
    logic [7:0]                  sel_b   [2];
    logic [3:0]                  link_st [2];
    port_split_pkg::pin_drive_s  drive_a [2];
    port_split_pkg::pin_drive_s  drive_b [2];
    logic [7:0]                  timeout_code; // Effective timeout code
    logic [7:0]                  pulse_code;   // Pulse code clamped to legal range
    logic [15:0]                 timeout_ms;
    logic [15:0]                 pulse_ms;
    logic [7:0]                  status;       // Live split status

    // OTP wins over the register; the register still reads what was written
    assign timeout_code = otp_timeout_valid ? otp_timeout_value : st_reg.stuck_timeout;
    assign timeout_ms   = 16'(timeout_code) * 16'(`TIMEOUT_UNIT_MS);

    // Out-of-range pulse codes are clamped so the pin never stays low too short or long
    always_comb begin
        if (st_reg.pulse_length < `PULSE_CODE_MIN) begin
            pulse_code = `PULSE_CODE_MIN;
        end else if (st_reg.pulse_length > `PULSE_CODE_MAX) begin
            pulse_code = `PULSE_CODE_MAX;
        end else begin
            pulse_code = st_reg.pulse_length;
        end
    end
    assign pulse_ms = 16'(pulse_code) * 16'(`PULSE_UNIT_MS);

    // Per-port enables, both gated by the global flag
    assign active[0] = st_reg.global_enable[`BIT_GLOBAL_ENABLE]
                       && st_reg.port_enable[`BIT_PORT5_ENABLE];
    assign active[1] = st_reg.global_enable[`BIT_GLOBAL_ENABLE]
                       && st_reg.port_enable[`BIT_PORT6_ENABLE];

    // Per-port views so the generate loop can index both ports alike
    assign pin_sel[0] = st_reg.port5_pin_sel;
    assign pin_sel[1] = st_reg.port6_pin_sel;
    assign sel_a[0]   = `SEL_PORT5_OPTION_A;
    assign sel_a[1]   = `SEL_PORT6_OPTION_A;
    assign sel_b[0]   = `SEL_PORT5_OPTION_B;
    assign sel_b[1]   = `SEL_PORT6_OPTION_B;
    assign link_st[0] = link_state_port5;
    assign link_st[1] = link_state_port6;

    // One watchdog and one pin router per split port
    for (genvar p = 0; p < 2; p++) begin : g_port
        link_watchdog u_watchdog (
            .clk        (clk),
            .reset      (reset),
            .enable     (active[p]),
            .ms_tick    (st_reg.ms_tick),
            .link_state (link_st[p]),
            .timeout_ms (timeout_ms),
            .pulse_ms   (pulse_ms),
            .power_low  (power_low[p])
        );

        // Unknown select codes leave both pins undriven; the pin sits high unless pulsing.
        // Split power is a plain driven output: no overcurrent input is sampled here.
        always_comb begin
            drive_a[p].level = !power_low[p];
            drive_b[p].level = !power_low[p];
            drive_a[p].oe_n  = !(active[p] && pin_sel[p] == sel_a[p]);
            drive_b[p].oe_n  = !(active[p] && pin_sel[p] == sel_b[p]);
        end
    end

    assign port5_option_a_pin = drive_a[0];
    assign port5_option_b_pin = drive_b[0];
    assign port6_option_a_pin = drive_a[1];
    assign port6_option_b_pin = drive_b[1];

    // USB 2.0 half keeps its usual control whatever the split setting
    assign port_power_control_pin = port_power_request;

    assign status = {4'h0, power_low, active};

    // Register writes, read mux and millisecond prescaler
    always_comb begin
        st_next         = st_reg;
        st_next.ms_tick = 1'b0;
        if (st_reg.ms_count == MS_LAST) begin
            st_next.ms_count = 17'h00000;
            st_next.ms_tick  = 1'b1;
        end else begin
            st_next.ms_count = st_reg.ms_count + 17'h00001;
        end
        if (cfg_wr_en) begin
            case (cfg_addr)
                `OFS_PORT_ENABLE:   st_next.port_enable   = cfg_wdata & `MASK_PORT_ENABLE;
                `OFS_GLOBAL_ENABLE: st_next.global_enable = {7'h00, cfg_wdata[0]};
                `OFS_PORT5_PIN_SEL: st_next.port5_pin_sel = cfg_wdata;
                `OFS_PORT6_PIN_SEL: st_next.port6_pin_sel = cfg_wdata;
                `OFS_STUCK_TIMEOUT: st_next.stuck_timeout = cfg_wdata;
                `OFS_PULSE_LENGTH:  st_next.pulse_length  = cfg_wdata;
                default:            st_next.port_enable   = st_reg.port_enable;
            endcase
        end
        // Unmapped offsets read zero
        case (cfg_addr)
            `OFS_PORT_ENABLE:   st_next.rdata = st_reg.port_enable;
            `OFS_GLOBAL_ENABLE: st_next.rdata = st_reg.global_enable;
            `OFS_PORT5_PIN_SEL: st_next.rdata = st_reg.port5_pin_sel;
            `OFS_PORT6_PIN_SEL: st_next.rdata = st_reg.port6_pin_sel;
            `OFS_STUCK_TIMEOUT: st_next.rdata = st_reg.stuck_timeout;
            `OFS_PULSE_LENGTH:  st_next.rdata = st_reg.pulse_length;
            `OFS_SPLIT_STATUS:  st_next.rdata = status;
            default:            st_next.rdata = 8'h00;
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg <= '{`RST_PORT_ENABLE, `RST_GLOBAL_ENABLE, `RST_PIN_SEL, `RST_PIN_SEL,
                        `RST_STUCK_TIMEOUT, `RST_PULSE_LENGTH, 8'h00, 17'h00000, 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign cfg_rdata = st_reg.rdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    port5_route_a: assert property (
        active[0] && st_reg.port5_pin_sel == `SEL_PORT5_OPTION_A
        |-> !port5_option_a_pin.oe_n && port5_option_b_pin.oe_n)
        else $error("Port 5 option A not routed");
    port6_route_a: assert property (
        active[1] && st_reg.port6_pin_sel == `SEL_PORT6_OPTION_B
        |-> !port6_option_b_pin.oe_n && port6_option_a_pin.oe_n)
        else $error("Port 6 option B not routed");
    enable_write_a: assert property (
        cfg_wr_en && cfg_addr == `OFS_PORT_ENABLE
        |=> st_reg.port_enable == ($past(cfg_wdata) & `MASK_PORT_ENABLE))
        else $error("Port enable write not stored with bit 0 clear");
    global_gate_a: assert property (
        !st_reg.global_enable[0] |-> port5_option_a_pin.oe_n && port5_option_b_pin.oe_n
        && port6_option_a_pin.oe_n && port6_option_b_pin.oe_n)
        else $error("Split pin driven while globally disabled");
    otp_override_a: assert property (
        otp_timeout_valid |-> timeout_ms == 16'(otp_timeout_value) * 16'(`TIMEOUT_UNIT_MS))
        else $error("OTP timeout not applied");
    usb2_power_a: assert property (port_power_control_pin == port_power_request)
        else $error("USB 2.0 power control altered");
    ms_tick_a: assert property (st_reg.ms_tick |=> !st_reg.ms_tick)
        else $error("Millisecond tick longer than one cycle");

    // Remaining select codes, global write masking and timer scaling
    port5_optb_a: assert property (
        active[0] && st_reg.port5_pin_sel == `SEL_PORT5_OPTION_B
        |-> !port5_option_b_pin.oe_n && port5_option_a_pin.oe_n)
        else $error("Port 5 option B not routed");
    port6_opta_a: assert property (
        active[1] && st_reg.port6_pin_sel == `SEL_PORT6_OPTION_A
        |-> !port6_option_a_pin.oe_n && port6_option_b_pin.oe_n)
        else $error("Port 6 option A not routed");
    odd_select_a: assert property (
        st_reg.port5_pin_sel != `SEL_PORT5_OPTION_A
        && st_reg.port5_pin_sel != `SEL_PORT5_OPTION_B
        |-> port5_option_a_pin.oe_n && port5_option_b_pin.oe_n)
        else $error("Port 5 pin driven by unknown select");
    global_write_a: assert property (
        cfg_wr_en && cfg_addr == `OFS_GLOBAL_ENABLE
        |=> st_reg.global_enable == {7'h00, $past(cfg_wdata[0])})
        else $error("Global enable write not stored with upper bits clear");
    pulse_clamp_a: assert property (
        pulse_ms >= 16'(`PULSE_CODE_MIN) * 16'(`PULSE_UNIT_MS)
        && pulse_ms <= 16'(`PULSE_CODE_MAX) * 16'(`PULSE_UNIT_MS))
        else $error("Pulse length outside its legal range");
    timeout_scale_a: assert property (
        !otp_timeout_valid
        |-> timeout_ms == 16'(st_reg.stuck_timeout) * 16'(`TIMEOUT_UNIT_MS))
        else $error("Timeout register not applied");

endmodule

//--- tb/split_power_device.sv
// Behavioural embedded SuperSpeed device that hangs off one split power pin.
// Assumes power is the resolved pin level, pulled low while nobody drives it.
module split_power_device (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       power,      // Resolved split power pin level
    input  wire logic       healthy,    // Link trains and keeps moving
    input  wire logic [3:0] stuck_code, // State the link freezes in when not healthy
    output logic      [3:0] link_state  // Link training state seen by the hub
);
    timeunit 1ns;
    timeprecision 1ps;

    // Link state as the hub sees it, one update per clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            link_state <= 4'h5;
        end else if (!power) begin
            // Unpowered device: the hub only sees receiver detection
            link_state <= 4'h5;
        end else if (healthy) begin
            // A live link never rests in one state
            link_state <= link_state + 4'h1;
        end else begin
            // Frozen link, the case the watchdog must catch
            link_state <= stuck_code;
        end
    end
endmodule

//--- tb/port_split_link_watchdog_tb_top.sv
// Self-checking bench for the port split watchdog with one device model per port.
// Assumes the design package and header compile first; millisecond shortened to 4 clocks.
`include "port_split_cfg.svh"

module port_split_link_watchdog_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MS = 4;          // Clocks per millisecond in this run
    localparam int TMO = 200 * MS;  // Timeout code 0x01 is 200 ms
    localparam int PLS = 350 * MS;  // Pulse code 0x07 is 350 ms

    logic                       clk;
    logic                       reset;
    logic                       cfg_wr_en;
    logic [15:0]                cfg_addr;
    logic [7:0]                 cfg_wdata;
    logic [7:0]                 cfg_rdata;
    logic                       otp_timeout_valid;
    logic [7:0]                 otp_timeout_value;
    logic [3:0]                 link_state_port5;
    logic [3:0]                 link_state_port6;
    logic [1:0]                 port_power_request;
    logic [1:0]                 port_power_control_pin;
    port_split_pkg::pin_drive_s p5a, p5b, p6a, p6b;
    logic [3:0]                 oe_n;     // Enables of all four pins
    logic [1:0]                 power;    // Resolved split power per port
    logic [1:0]                 healthy;  // Device link behaviour per port
    logic [7:0]                 codes;    // Frozen state per port
    int                         err_total;
    int                         n_compared;
    int                         cycles = 0;

    // Undriven pins fall to the pull-down, so the device loses power
    assign power[0] = !p5a.oe_n ? p5a.level : (!p5b.oe_n ? p5b.level : 1'b0);
    assign power[1] = !p6a.oe_n ? p6a.level : (!p6b.oe_n ? p6b.level : 1'b0);
    assign oe_n = {p6b.oe_n, p6a.oe_n, p5b.oe_n, p5a.oe_n};

    port_split_link_watchdog #(.MS_CYCLES(MS)) u_dut (
        .clk(clk), .reset(reset), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .otp_timeout_valid(otp_timeout_valid),
        .otp_timeout_value(otp_timeout_value), .link_state_port5(link_state_port5),
        .link_state_port6(link_state_port6), .port_power_request(port_power_request),
        .port_power_control_pin(port_power_control_pin), .port5_option_a_pin(p5a),
        .port5_option_b_pin(p5b), .port6_option_a_pin(p6a), .port6_option_b_pin(p6b));

    split_power_device u_dev5 (.clk(clk), .reset(reset), .power(power[0]),
        .healthy(healthy[0]), .stuck_code(codes[3:0]), .link_state(link_state_port5));
    split_power_device u_dev6 (.clk(clk), .reset(reset), .power(power[1]),
        .healthy(healthy[1]), .stuck_code(codes[7:4]), .link_state(link_state_port6));

    // Free-running clock at 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard: the planned run needs about 25000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            results();
        end
    end

    // Single comparison point; unknowns never match
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_wr_en <= 1'b1;
        cfg_addr  <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr_en <= 1'b0;
    endtask

    // Read answers one cycle after the address is taken
    task automatic reg_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        cfg_addr <= a;
        @(posedge clk);
        @(posedge clk);
        #1;
        check(what, {8'h00, cfg_rdata}, {8'h00, exp});
    endtask

    // Wait for a port's power level, bounded, counting cycles
    task automatic wait_lvl(input int p, input logic v, input int max, output int n);
        n = 0;
        while (power[p] !== v && n < max) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // Registers come out of reset with their documented values
    task automatic t_reset_values();
        reg_chk("port enable", 16'h3C48, 8'h00);
        reg_chk("global enable", 16'h4141, 8'h00);
        reg_chk("timeout", 16'h4171, 8'h05);
        reg_chk("pulse length", 16'h4176, `RST_PULSE_LENGTH);
        reg_chk("unmapped", 16'h1234, 8'h00);
    endtask

    // Reserved bits keep their fixed values
    task automatic t_reserved();
        wr(16'h3C48, 8'hFF);
        reg_chk("port enable bit 0", 16'h3C48, 8'hFE);
        wr(16'h4141, 8'hFF);
        reg_chk("global upper bits", 16'h4141, 8'h01);
        wr(16'h3C48, 8'h00);
        wr(16'h4141, 8'h00);
    endtask

    // Every select code drives only its pin, and only with both enables
    task automatic t_routing();
        logic [7:0] sel [4];
        sel = '{8'h42, 8'h05, 8'h06, 8'h04};
        for (int i = 0; i < 4; i++) begin
            wr(i < 2 ? 16'h416E : 16'h416F, sel[i]);
            wr(16'h3C48, i < 2 ? 8'h20 : 8'h40);
            #1;
            check("pins without global", {12'h000, oe_n}, 16'h000F);
            wr(16'h4141, 8'h01);
            #1;
            check("pin drive", {12'h000, oe_n}, {12'h000, ~(4'h1 << i)});
            wr(16'h3C48, 8'h00);
            #1;
            check("pins without port", {12'h000, oe_n}, 16'h000F);
            wr(16'h4141, 8'h00);
        end
    endtask

    // USB 2.0 power follows the hub while splitting is active
    task automatic t_power_copy();
        for (int v = 0; v < 4; v++) begin
            @(posedge clk);
            port_power_request <= v[1:0];
            #1;
            check("usb2 power", {14'h0, port_power_control_pin}, v[15:0]);
        end
    endtask

    // Frozen link in code c: pulse after the timeout, pulse length, optional repeat
    task automatic t_stuck(input int p, input logic [3:0] c, input logic again);
        int n;
        @(posedge clk);
        codes[p*4 +: 4] <= c;
        healthy[p] <= 1'b0;
        wait_lvl(p, 1'b0, 2000, n);
        check("fall time", 16'(n inside {[TMO-MS-2:TMO+MS+3]}), 16'h0001);
        wait_lvl(p, 1'b1, 2000, n);
        check("pulse length", 16'(n inside {[PLS-MS-2:PLS+MS+3]}), 16'h0001);
        if (again) begin
            wait_lvl(p, 1'b0, 2000, n);
            check("repeat fall", 16'(n inside {[TMO-MS-2:TMO+MS+6]}), 16'h0001);
            wait_lvl(p, 1'b1, 2000, n);
        end
        healthy[p] <= 1'b1;
        repeat (20) @(posedge clk);
    endtask

    // No pulse may come for a moving link, a healthy code or a disabled timeout
    task automatic t_quiet(input int p, input logic h, input logic [3:0] c);
        int n;
        @(posedge clk);
        codes[p*4 +: 4] <= c;
        healthy[p] <= h;
        wait_lvl(p, 1'b0, TMO + 400, n);
        check("no pulse", {15'h0, power[p]}, 16'h0001);
        healthy[p] <= 1'b1;
    endtask

    // Closing report and verdict
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        cfg_wr_en = 1'b0;
        cfg_addr = 16'h0000;
        cfg_wdata = 8'h00;
        otp_timeout_valid = 1'b0;
        otp_timeout_value = 8'h00;
        port_power_request = 2'b00;
        healthy = 2'b11;
        codes = 8'h55;
        err_total = 0;
        n_compared = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_reset_values();
        t_reserved();
        t_routing();
        // Port 5 on option A, port 6 on option B, short timeout and pulse
        wr(16'h416E, 8'h42);
        wr(16'h416F, 8'h04);
        wr(16'h3C48, 8'h60);
        wr(16'h4141, 8'h01);
        wr(16'h4171, 8'h01);
        wr(16'h4176, 8'h07);
        reg_chk("port5 select", 16'h416E, 8'h42);
        reg_chk("port6 select", 16'h416F, 8'h04);
        reg_chk("split status", 16'h4177, 8'h03);
        t_power_copy();
        for (int c = 4; c <= 9; c++)
            t_stuck(c == 7 ? 1 : 0, c[3:0], c == 9);
        t_quiet(0, 1'b1, 4'h5);
        t_quiet(0, 1'b0, 4'h3);
        t_quiet(1, 1'b0, 4'hA);
        wr(16'h4171, 8'h00);
        t_quiet(0, 1'b0, 4'h5);
        // OTP code overrides the disabled register
        @(posedge clk);
        otp_timeout_value <= 8'h01;
        otp_timeout_valid <= 1'b1;
        t_stuck(0, 4'h6, 1'b0);
        reg_chk("timeout under otp", 16'h4171, 8'h00);
        results();
    end
endmodule
